// ### core/tcf_timer16.v
`timescale 1ns/1ps
// Contract
// RULE1: Filter needs four equal samples before changing
// RULE2: Edge select bit: zero falling, one rising
// RULE3: Capture copies counter, sets capture flag
// RULE4: Capture register as top disables pin capture
// RULE5: Clock select zero stops; one-five internal taps
// RULE6: Six counts falling, seven rising external edges
// RULE7: External pin counts even when driven outward
// RULE8: Force strobe applies match action, non-PWM only
// RULE9: Force sets no flag, clears no counter
// RULE10: Force strobe bits always read zero
// RULE11: Shared high-byte latch makes 16-bit access atomic
// RULE12: Counter write blocks next timer-clock match
// RULE13: Compare registers compared continuously, drive outputs; here matches move the outputs in non-PWM modes only
// RULE14: Capture source is pin or comparator
// RULE15: Interrupt needs mask, global enable and flag
// RULE16: Capture-top modes set capture flag at top
// RULE17: Match flag set next timer clock cycle
// RULE18: Vector or write-one clears flag; zero keeps
// RULE19: Overflow flag set where waveform mode defines
// RULE20: Reserved bits read zero; software writes zero
// RULE21: Non-PWM output mode: off, toggle, clear, set
// RULE22: Software writes high first, reads low first
`include "tcf_timer16_regs.vh"

module tcf_timer16 (
    input wire sys_clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire capture_pin,
    input wire comparator_out,
    input wire external_count_pin,
    input wire global_irq_en,
    input wire [3:0] vector_ack,
    output wire irq_capture,
    output wire irq_match_a,
    output wire irq_match_b,
    output wire irq_overflow,
    output wire wave_out_a,
    output wire wave_out_b,
    output wire wave_oe_a,
    output wire wave_oe_b
);

    reg [7:0] control_reg_a;
    reg [7:0] control_reg_b;
    reg [7:0] irq_mask_reg;
    reg [7:0] irq_flag_reg;
    reg [7:0] misc_reg;
    reg [7:0] high_byte_latch;
    reg [15:0] count_value;
    reg [15:0] capture_reg;
    reg count_down;
    reg match_block;
    reg [9:0] prescale;

    // Two-stage synchronisers for every asynchronous input
    reg [1:0] ext_sync;
    reg [1:0] cap_sync;
    reg [1:0] cmp_sync;
    reg ext_prev;
    reg [`TCF_FILTER_LEN-1:0] cap_hist;
    reg cap_filtered;
    reg cap_prev;

    wire [3:0] waveform_mode_sel;
    wire [2:0] clock_source_sel;
    wire capture_noise_filter_en;
    wire capture_edge_select;
    wire wr_count_l;
    wire non_pwm;
    wire dual_slope;
    wire fast_pwm;
    wire capture_is_top;
    reg [15:0] top_value;
    reg tick;
    wire cap_raw;
    wire cap_src;
    wire cap_event;
    wire top_capture_event;
    wire overflow_event;
    wire [1:0] match_event;
    wire [7:0] flag_set;
    wire [7:0] flag_clear;
    wire [15:0] cmp_val_0;
    wire [15:0] cmp_val_1;
    wire [1:0] wave_bits;

    assign waveform_mode_sel = {control_reg_b[`TCF_CB_WGM_HI:`TCF_CB_WGM_LO],
                                control_reg_a[`TCF_CA_WGM_HI:`TCF_CA_WGM_LO]};
    assign clock_source_sel = control_reg_b[`TCF_CB_CS_HI:`TCF_CB_CS_LO];
    assign capture_noise_filter_en = control_reg_b[`TCF_CB_FILTER];
    assign capture_edge_select = control_reg_b[`TCF_CB_EDGE];
    assign wr_count_l = reg_wr && (reg_addr == `TCF_OFS_COUNT_L);

    // Mode classes: normal, CLEAR_ON_MATCH_MODE and the reserved code behave as non-PWM counting
    assign non_pwm = (waveform_mode_sel == 4'd0) || (waveform_mode_sel == 4'd4) ||
                     (waveform_mode_sel == 4'd12) || (waveform_mode_sel == 4'd13);
    assign dual_slope = (waveform_mode_sel == 4'd1) || (waveform_mode_sel == 4'd2) ||
                        (waveform_mode_sel == 4'd3) || (waveform_mode_sel == 4'd8) ||
                        (waveform_mode_sel == 4'd9) || (waveform_mode_sel == 4'd10) ||
                        (waveform_mode_sel == 4'd11);
    assign fast_pwm = !non_pwm && !dual_slope;
    assign capture_is_top = (waveform_mode_sel == 4'd8) || (waveform_mode_sel == 4'd10) ||
                            (waveform_mode_sel == 4'd12) || (waveform_mode_sel == 4'd14);

    always @* begin
        case (waveform_mode_sel)
            4'd1, 4'd5: top_value = `TCF_TOP_8B;
            4'd2, 4'd6: top_value = `TCF_TOP_9B;
            4'd3, 4'd7: top_value = `TCF_TOP_10B;
            4'd4, 4'd9, 4'd11, 4'd15: top_value = cmp_val_0;
            4'd8, 4'd10, 4'd12, 4'd14: top_value = capture_reg;
            default: top_value = `TCF_TOP_MAX;
        endcase
    end

    // Free-running prescaler; a tap fires once per divisor period
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale <= 10'h000;
        end else begin
            prescale <= prescale + 10'h001;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_sync <= 2'b00;
            cap_sync <= 2'b00;
            cmp_sync <= 2'b00;
            ext_prev <= 1'b0;
        end else begin
            // Pin is sampled regardless of its direction
            ext_sync <= {ext_sync[0], external_count_pin}; // RULE7
            cap_sync <= {cap_sync[0], capture_pin};
            cmp_sync <= {cmp_sync[0], comparator_out};
            ext_prev <= ext_sync[1];
        end
    end

    always @* begin
        case (clock_source_sel)
            `TCF_CS_STOP: tick = 1'b0; // RULE5
            `TCF_CS_DIV1: tick = 1'b1; // RULE5
            `TCF_CS_DIV8: tick = (prescale & `TCF_PRE_M8) == `TCF_PRE_M8; // RULE5
            `TCF_CS_DIV64: tick = (prescale & `TCF_PRE_M64) == `TCF_PRE_M64; // RULE5
            `TCF_CS_DIV256: tick = (prescale & `TCF_PRE_M256) == `TCF_PRE_M256; // RULE5
            `TCF_CS_DIV1024: tick = prescale == `TCF_PRE_M1024; // RULE5
            `TCF_CS_EXT_FALL: tick = ext_prev && !ext_sync[1]; // RULE6
            default: tick = !ext_prev && ext_sync[1]; // RULE6
        endcase
    end

    assign cap_raw = misc_reg[`TCF_MISC_CAP_COMP] ? cmp_sync[1] : cap_sync[1]; // RULE14

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_hist <= {`TCF_FILTER_LEN{1'b0}};
            cap_filtered <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            cap_hist <= {cap_hist[`TCF_FILTER_LEN-2:0], cap_raw};
            if (&cap_hist) begin
                cap_filtered <= 1'b1; // RULE1
            end else if (~|cap_hist) begin
                cap_filtered <= 1'b0; // RULE1
            end
            cap_prev <= cap_src;
        end
    end

    assign cap_src = capture_noise_filter_en ? cap_filtered : cap_raw; // RULE1
    // Pin path is cut off while the capture register defines the period
    assign cap_event = !capture_is_top && // RULE4
                       (capture_edge_select ? (!cap_prev && cap_src) // RULE2
                                            : (cap_prev && !cap_src)); // RULE2
    assign top_capture_event = capture_is_top && tick && !count_down &&
                               (count_value == top_value); // RULE16

    // Overflow point depends on the waveform mode
    assign overflow_event = tick && (non_pwm ? (count_value == `TCF_TOP_MAX) // RULE19
                          : fast_pwm ? (count_value == top_value) // RULE19
                          : (count_down && (count_value == `TCF_BOTTOM))); // RULE19

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_value <= `TCF_RST_WORD;
            count_down <= 1'b0;
            match_block <= 1'b0;
        end else begin
            if (wr_count_l) begin
                count_value <= {high_byte_latch, reg_wdata}; // RULE11
                match_block <= 1'b1; // RULE12
            end else if (tick) begin
                match_block <= 1'b0; // RULE12
                if (dual_slope) begin
                    if (!count_down && count_value >= top_value) begin
                        count_down <= 1'b1;
                        count_value <= count_value - 16'h0001;
                    end else if (count_down && count_value == `TCF_BOTTOM) begin
                        count_down <= 1'b0;
                        count_value <= count_value + 16'h0001;
                    end else if (count_down) begin
                        count_value <= count_value - 16'h0001;
                    end else begin
                        count_value <= count_value + 16'h0001;
                    end
                end else begin
                    count_down <= 1'b0;
                    // Forced strobes never reach this clear
                    if (count_value == top_value) begin
                        count_value <= `TCF_BOTTOM; // RULE9
                    end else begin
                        count_value <= count_value + 16'h0001;
                    end
                end
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_cmp
            reg [15:0] compare_value;
            reg wave;
            wire [7:0] ofs_l;
            wire [1:0] compare_output_mode;
            wire force_compare;
            wire act;

            assign ofs_l = (ch == 0) ? `TCF_OFS_CMPA_L : `TCF_OFS_CMPB_L;
            assign compare_output_mode = (ch == 0) ?
                control_reg_a[`TCF_CA_COM_A_HI:`TCF_CA_COM_A_HI-1] :
                control_reg_a[`TCF_CA_COM_B_HI:`TCF_CA_COM_B_HI-1];
            assign force_compare = reg_wr && (reg_addr == `TCF_OFS_CTRL_C) && non_pwm && // RULE8
                reg_wdata[(ch == 0) ? `TCF_CC_FORCE_A : `TCF_CC_FORCE_B];
            assign match_event[ch] = tick && !match_block && // RULE12
                                     (count_value == compare_value); // RULE13
            assign act = (match_event[ch] && non_pwm) || force_compare; // RULE8

            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    compare_value <= `TCF_RST_WORD;
                    wave <= 1'b0;
                end else begin
                    if (reg_wr && reg_addr == ofs_l) begin
                        compare_value <= {high_byte_latch, reg_wdata}; // RULE11
                    end
                    if (act) begin
                        case (compare_output_mode)
                            `TCF_COM_TOGGLE: wave <= !wave; // RULE21
                            `TCF_COM_CLEAR: wave <= 1'b0; // RULE21
                            `TCF_COM_SET: wave <= 1'b1; // RULE21
                            default: wave <= wave; // RULE21
                        endcase
                    end
                end
            end

            assign wave_bits[ch] = wave;
        end
    endgenerate

    assign cmp_val_0 = g_cmp[0].compare_value;
    assign cmp_val_1 = g_cmp[1].compare_value;
    assign wave_out_a = wave_bits[0]; // RULE13
    assign wave_out_b = wave_bits[1]; // RULE13
    // Pin is only driven while an output mode is selected
    assign wave_oe_a = control_reg_a[`TCF_CA_COM_A_HI:`TCF_CA_COM_A_HI-1] != `TCF_COM_OFF;
    assign wave_oe_b = control_reg_a[`TCF_CA_COM_B_HI:`TCF_CA_COM_B_HI-1] != `TCF_COM_OFF;

    // Capture register: hardware capture beats a same-cycle software write
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_reg <= `TCF_RST_WORD;
        end else if (cap_event) begin
            capture_reg <= count_value; // RULE3
        end else if (reg_wr && reg_addr == `TCF_OFS_CAPT_L) begin
            capture_reg <= {high_byte_latch, reg_wdata}; // RULE11
        end
    end

    // Flags: hardware set wins over any clear in the same cycle
    assign flag_set = {2'b00, (cap_event || top_capture_event), 2'b00, // RULE3 RULE16
                       match_event[1], match_event[0], overflow_event}; // RULE17 RULE19
    assign flag_clear = ((reg_wr && reg_addr == `TCF_OFS_FLAGS) ? reg_wdata : 8'h00) | // RULE18
                        {2'b00, vector_ack[3], 2'b00, vector_ack[2:0]}; // RULE18

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flag_reg <= `TCF_RST_BYTE;
        end else begin
            irq_flag_reg <= ((irq_flag_reg & ~flag_clear) | flag_set) & `TCF_FLAG_IMPL; // RULE18
        end
    end

    assign irq_capture = global_irq_en && irq_mask_reg[`TCF_BIT_CAPTURE] && // RULE15
                         irq_flag_reg[`TCF_BIT_CAPTURE];
    assign irq_match_b = global_irq_en && irq_mask_reg[`TCF_BIT_MATCH_B] && // RULE15
                         irq_flag_reg[`TCF_BIT_MATCH_B];
    assign irq_match_a = global_irq_en && irq_mask_reg[`TCF_BIT_MATCH_A] && // RULE15
                         irq_flag_reg[`TCF_BIT_MATCH_A];
    assign irq_overflow = global_irq_en && irq_mask_reg[`TCF_BIT_OVERFLOW] && // RULE15
                          irq_flag_reg[`TCF_BIT_OVERFLOW];

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_reg_a <= `TCF_RST_BYTE;
            control_reg_b <= `TCF_RST_BYTE;
            irq_mask_reg <= `TCF_RST_BYTE;
            misc_reg <= `TCF_RST_BYTE;
            high_byte_latch <= `TCF_RST_BYTE;
        end else begin
            if (reg_wr) begin
                if (reg_addr == `TCF_OFS_CTRL_A) begin
                    control_reg_a <= reg_wdata & 8'hf3;
                end else if (reg_addr == `TCF_OFS_CTRL_B) begin
                    // Reserved bit is kept at zero whatever is written
                    control_reg_b <= reg_wdata & 8'hdf; // RULE20
                end else if (reg_addr == `TCF_OFS_MASK) begin
                    irq_mask_reg <= reg_wdata & `TCF_FLAG_IMPL; // RULE20
                end else if (reg_addr == `TCF_OFS_MISC) begin
                    misc_reg <= reg_wdata & 8'h01;
                end else if (reg_addr == `TCF_OFS_COUNT_H || reg_addr == `TCF_OFS_CAPT_H ||
                             reg_addr == `TCF_OFS_CMPA_H || reg_addr == `TCF_OFS_CMPB_H) begin
                    high_byte_latch <= reg_wdata; // RULE11
                end
            end else if (reg_rd) begin
                // Low-byte read snapshots the high byte for the following read
                if (reg_addr == `TCF_OFS_COUNT_L) begin
                    high_byte_latch <= count_value[15:8]; // RULE11
                end else if (reg_addr == `TCF_OFS_CAPT_L) begin
                    high_byte_latch <= capture_reg[15:8]; // RULE11
                end else if (reg_addr == `TCF_OFS_CMPA_L) begin
                    high_byte_latch <= cmp_val_0[15:8]; // RULE11
                end else if (reg_addr == `TCF_OFS_CMPB_L) begin
                    high_byte_latch <= cmp_val_1[15:8]; // RULE11
                end
            end
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `TCF_RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == `TCF_OFS_FLAGS) begin
                reg_rdata <= irq_flag_reg; // RULE20
            end else if (reg_addr == `TCF_OFS_MASK) begin
                reg_rdata <= irq_mask_reg; // RULE20
            end else if (reg_addr == `TCF_OFS_CTRL_A) begin
                reg_rdata <= control_reg_a;
            end else if (reg_addr == `TCF_OFS_CTRL_B) begin
                reg_rdata <= control_reg_b;
            end else if (reg_addr == `TCF_OFS_CTRL_C) begin
                reg_rdata <= 8'h00; // RULE10
            end else if (reg_addr == `TCF_OFS_MISC) begin
                reg_rdata <= misc_reg;
            end else if (reg_addr == `TCF_OFS_COUNT_L) begin
                reg_rdata <= count_value[7:0];
            end else if (reg_addr == `TCF_OFS_CAPT_L) begin
                reg_rdata <= capture_reg[7:0];
            end else if (reg_addr == `TCF_OFS_CMPA_L) begin
                reg_rdata <= cmp_val_0[7:0];
            end else if (reg_addr == `TCF_OFS_CMPB_L) begin
                reg_rdata <= cmp_val_1[7:0];
            end else if (reg_addr == `TCF_OFS_COUNT_H || reg_addr == `TCF_OFS_CAPT_H ||
                         reg_addr == `TCF_OFS_CMPA_H || reg_addr == `TCF_OFS_CMPB_H) begin
                reg_rdata <= high_byte_latch; // RULE11
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ### pkg/tcf_timer16_regs.vh
`ifndef TCF_TIMER16_REGS_VH
`define TCF_TIMER16_REGS_VH

// Register offsets on the 8-bit register port
`define TCF_OFS_FLAGS 8'h36
`define TCF_OFS_MASK 8'h6f
`define TCF_OFS_CTRL_A 8'h80
`define TCF_OFS_CTRL_B 8'h81
`define TCF_OFS_CTRL_C 8'h82
`define TCF_OFS_MISC 8'h83
`define TCF_OFS_COUNT_L 8'h84
`define TCF_OFS_COUNT_H 8'h85
`define TCF_OFS_CAPT_L 8'h86
`define TCF_OFS_CAPT_H 8'h87
`define TCF_OFS_CMPA_L 8'h88
`define TCF_OFS_CMPA_H 8'h89
`define TCF_OFS_CMPB_L 8'h8a
`define TCF_OFS_CMPB_H 8'h8b

// Reset values
`define TCF_RST_BYTE 8'h00
`define TCF_RST_WORD 16'h0000

// Flag and mask bit positions
`define TCF_BIT_CAPTURE 5
`define TCF_BIT_MATCH_B 2
`define TCF_BIT_MATCH_A 1
`define TCF_BIT_OVERFLOW 0
`define TCF_FLAG_IMPL 8'h27

// Control B fields
`define TCF_CB_FILTER 7
`define TCF_CB_EDGE 6
`define TCF_CB_RSVD 5
`define TCF_CB_WGM_HI 4
`define TCF_CB_WGM_LO 3
`define TCF_CB_CS_HI 2
`define TCF_CB_CS_LO 0

// Control A fields
`define TCF_CA_COM_A_HI 7
`define TCF_CA_COM_B_HI 5
`define TCF_CA_WGM_HI 1
`define TCF_CA_WGM_LO 0

// Control C force bits
`define TCF_CC_FORCE_A 7
`define TCF_CC_FORCE_B 6

// Misc register: capture source select
`define TCF_MISC_CAP_COMP 0

// Clock select codes
`define TCF_CS_STOP 3'h0
`define TCF_CS_DIV1 3'h1
`define TCF_CS_DIV8 3'h2
`define TCF_CS_DIV64 3'h3
`define TCF_CS_DIV256 3'h4
`define TCF_CS_DIV1024 3'h5
`define TCF_CS_EXT_FALL 3'h6
`define TCF_CS_EXT_RISE 3'h7

// Prescaler tap masks (divisor minus one)
`define TCF_PRE_M8 10'h007
`define TCF_PRE_M64 10'h03f
`define TCF_PRE_M256 10'h0ff
`define TCF_PRE_M1024 10'h3ff

// Compare output modes, non-PWM
`define TCF_COM_OFF 2'h0
`define TCF_COM_TOGGLE 2'h1
`define TCF_COM_CLEAR 2'h2
`define TCF_COM_SET 2'h3

// Fixed top values
`define TCF_TOP_MAX 16'hffff
`define TCF_TOP_8B 16'h00ff
`define TCF_TOP_9B 16'h01ff
`define TCF_TOP_10B 16'h03ff
`define TCF_BOTTOM 16'h0000

// Noise filter sample count
`define TCF_FILTER_LEN 4

`endif

// ### verification/tcf_timer16_monitor.sv
`timescale 1ns/1ps
module tcf_timer16_monitor (
    input wire sys_clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire global_irq_en,
    input wire [3:0] vector_ack,
    input wire irq_capture,
    input wire irq_match_a,
    input wire irq_match_b,
    input wire irq_overflow,
    input wire wave_oe_a,
    input wire wave_oe_b
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_ctrl_c_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h82 |-> reg_rdata == 8'h00)
        else $error("control C read back nonzero");
    a_flag_rsvd_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h36 |-> (reg_rdata & 8'hd8) == 8'h00)
        else $error("flag reserved bits nonzero");
    a_mask_rsvd_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h6f |-> (reg_rdata & 8'hd8) == 8'h00)
        else $error("mask reserved bits nonzero");
    a_ctrl_b_rsvd: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h81 |-> reg_rdata[5] == 1'b0)
        else $error("control B reserved bit nonzero");
    a_irq_needs_global: assert property (
        (irq_capture || irq_match_a || irq_match_b || irq_overflow) |-> global_irq_en)
        else $error("interrupt raised without global enable");
    // Enables follow the mode field only, so they may move only after a control A write
    a_oe_write_cause: assert property (
        $changed({wave_oe_a, wave_oe_b}) |-> $past(reg_wr) && $past(reg_addr) == 8'h80)
        else $error("output enable changed without control A write");
    a_cap_irq_clear: assert property (
        $fell(irq_capture) |-> !global_irq_en || $past(vector_ack[3]) || $past(reg_wr))
        else $error("capture interrupt dropped without cause");
    a_ovf_irq_clear: assert property (
        $fell(irq_overflow) |-> !global_irq_en || $past(vector_ack[0]) || $past(reg_wr))
        else $error("overflow interrupt dropped without cause");
endmodule

bind tcf_timer16 tcf_timer16_monitor tcf_timer16_monitor_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
    .vector_ack(vector_ack), .irq_capture(irq_capture), .irq_match_a(irq_match_a),
    .irq_match_b(irq_match_b), .irq_overflow(irq_overflow), .wave_oe_a(wave_oe_a),
    .wave_oe_b(wave_oe_b));

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    reg sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg capture_pin = 1'b0, comparator_out = 1'b0, external_count_pin = 1'b0;
    reg global_irq_en = 1'b0, rd_d = 1'b0, pin_req = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg [3:0] vector_ack = 4'h0;
    wire [7:0] reg_rdata;
    wire irq_capture, irq_match_a, irq_match_b, irq_overflow;
    wire wave_out_a, wave_out_b, wave_oe_a, wave_oe_b;
    wire [7:0] pins = {wave_oe_a, wave_oe_b, wave_out_a, wave_out_b,
        irq_capture, irq_match_b, irq_match_a, irq_overflow};
    logic [15:0] notes[$];
    int miscompares = 0, n_checks = 0, cycles = 0;

    tcf_timer16 tcf_timer16_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .capture_pin(capture_pin), .comparator_out(comparator_out),
        .external_count_pin(external_count_pin), .global_irq_en(global_irq_en),
        .vector_ack(vector_ack), .irq_capture(irq_capture), .irq_match_a(irq_match_a),
        .irq_match_b(irq_match_b), .irq_overflow(irq_overflow), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .wave_oe_a(wave_oe_a), .wave_oe_b(wave_oe_b));

    always #50 sys_clk = ~sys_clk;

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Notes are {low, high} windows, since prescaled counts may land one tick apart
    always @(posedge sys_clk) begin : watch
        logic [15:0] n;
        logic [7:0] got;
        got = rd_d ? reg_rdata : pins;
        if (rd_d || pin_req) begin
            n = notes.pop_front();
            n_checks++;
            if ((got >= n[15:8] && got <= n[7:0]) !== 1'b1) begin
                miscompares++;
                $display("CHECK FAILED %s expected %h..%h seen %h",
                    rd_d ? "reg_rdata" : "pins", n[15:8], n[7:0], got);
            end
        end
        rd_d <= reg_rd;
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            $display("timeout");
            tally_and_finish;
        end
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] hi);
        @(posedge sys_clk);
        if (!w) notes.push_back({d, hi});
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 8'h00);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        bus(1'b0, a, lo, hi);
    endtask
    // High byte goes first on writes and last on reads through the shared latch
    task wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a + 8'h01, d[15:8]);
        wr(a, d[7:0]);
    endtask
    task rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0], e[7:0]);
        rd(a + 8'h01, e[15:8], e[15:8]);
    endtask
    task pchk(input logic [7:0] e);
        @(posedge sys_clk);
        notes.push_back({e, e});
        pin_req <= 1'b1;
        @(posedge sys_clk);
        pin_req <= 1'b0;
    endtask
    task cap(input logic lvl, input logic [7:0] f);
        @(posedge sys_clk);
        capture_pin <= lvl;
        tick(8);
        rd(8'h36, f, f);
    endtask

    initial begin : main
        int div[6] = '{0, 1, 8, 64, 256, 1024};
        logic [15:0] v;
        int i;
        v = 16'($urandom(32'h15fc));
        tick(3);
        reset_n <= 1'b1;
        for (i = 0; i < 12; i++)
            rd(8'h80 + i[7:0], 8'h00, 8'h00);
        rd(8'h36, 8'h00, 8'h00);
        rd(8'h6f, 8'h00, 8'h00);
        rd(8'h00, 8'h00, 8'h00);
        $display("test reset values done");
        for (i = 0; i < 3; i++) begin
            v = 16'($urandom);
            wr16(8'h86 + 8'h02 * i[7:0], v);
            rd16(8'h86 + 8'h02 * i[7:0], v);
        end
        v = 16'($urandom);
        wr(8'h6f, v[7:0]);
        rd(8'h6f, v[7:0] & 8'h27, v[7:0] & 8'h27);
        wr(8'h81, v[15:8] & 8'hd8);
        rd(8'h81, v[15:8] & 8'hd8, v[15:8] & 8'hd8);
        wr(8'h82, 8'h3f);
        rd(8'h82, 8'h00, 8'h00);
        wr(8'h81, 8'h00);
        $display("test register access done");
        for (i = 0; i < 6; i++) begin
            wr16(8'h84, 16'h0000);
            wr(8'h81, i[7:0]);
            tick(div[i] * 16);
            wr(8'h81, 8'h00);
            rd(8'h84, i ? 8'h0f : 8'h00, i ? 8'h13 : 8'h00);
            rd(8'h85, 8'h00, 8'h00);
        end
        for (i = 6; i < 8; i++) begin
            wr16(8'h84, 16'h0000);
            wr(8'h81, i[7:0]);
            repeat (5) begin
                external_count_pin <= 1'b1;
                tick(4);
                external_count_pin <= 1'b0;
                tick(4);
            end
            tick(4);
            wr(8'h81, 8'h00);
            rd16(8'h84, 16'h0005);
        end
        $display("test clock select done");
        wr(8'h36, 8'hff);
        wr(8'h6f, 8'h27);
        global_irq_en <= 1'b1;
        wr16(8'h84, 16'h1234);
        wr(8'h81, 8'h40);
        cap(1'b1, 8'h20);
        pchk(8'h08);
        rd16(8'h86, 16'h1234);
        vector_ack <= 4'h8;
        tick(1);
        vector_ack <= 4'h0;
        cap(1'b0, 8'h00);
        wr(8'h81, 8'h00);
        wr16(8'h84, 16'h00ab);
        cap(1'b1, 8'h00);
        cap(1'b0, 8'h20);
        rd16(8'h86, 16'h00ab);
        wr(8'h36, 8'hdf);
        rd(8'h36, 8'h20, 8'h20);
        wr(8'h36, 8'h20);
        wr(8'h81, 8'hc0);
        capture_pin <= 1'b1;
        tick(1);
        cap(1'b0, 8'h00);
        cap(1'b1, 8'h20);
        wr(8'h36, 8'h20);
        wr(8'h81, 8'h40);
        cap(1'b0, 8'h00);
        wr(8'h83, 8'h01);
        comparator_out <= 1'b1;
        tick(8);
        rd(8'h36, 8'h20, 8'h20);
        wr(8'h36, 8'h20);
        comparator_out <= 1'b0;
        tick(4);
        wr(8'h83, 8'h00);
        wr16(8'h84, 16'h0000);
        wr(8'h81, 8'h58);
        cap(1'b1, 8'h00);
        cap(1'b0, 8'h00);
        $display("test capture done");
        wr16(8'h88, 16'h0005);
        wr16(8'h8a, 16'h0100);
        for (i = 0; i < 2; i++) begin
            wr(8'h36, 8'hff);
            wr16(8'h84, 16'h0004 + i[15:0]);
            wr(8'h81, 8'h01);
            tick(3);
            wr(8'h81, 8'h00);
            rd(8'h36, i ? 8'h00 : 8'h02, i ? 8'h00 : 8'h02);
            pchk(i ? 8'h00 : 8'h02);
        end
        wr16(8'h84, 16'hfff0);
        wr(8'h81, 8'h01);
        tick(30);
        wr(8'h81, 8'h00);
        rd(8'h36, 8'h03, 8'h03);
        pchk(8'h03);
        vector_ack <= 4'h1;
        tick(1);
        vector_ack <= 4'h0;
        rd(8'h36, 8'h02, 8'h02);
        global_irq_en <= 1'b0;
        pchk(8'h00);
        wr(8'h36, 8'hff);
        for (i = 0; i < 4; i++) begin
            wr(8'h80, i < 2 ? 8'hc0 - 8'h40 * i[7:0] : 8'h40);
            wr(8'h82, 8'h80);
            pchk(i[0] ? 8'h80 : 8'ha0);
        end
        rd(8'h36, 8'h00, 8'h00);
        wr(8'h80, 8'hc1);
        wr(8'h82, 8'h80);
        pchk(8'h80);
        wr(8'h80, 8'h30);
        wr(8'h82, 8'h40);
        pchk(8'h50);
        wr16(8'h84, 16'h0000);
        wr(8'h81, 8'h19);
        tick(200);
        wr(8'h81, 8'h00);
        rd(8'h36, 8'h22, 8'h22);
        rd(8'h84, 8'h1d, 8'h1f);
        $display("test compare and force done");
        tally_and_finish;
    end
endmodule
